// ---- core/general_purpose_io_port.sv ----
// 26-pin general purpose io port with register bank and pin muxing
`timescale 1ns/100ps
// What this block does
// - all pins undriven while reset held
// - low power: most pins high impedance
// - low power: pins 9-11 use sleep config
// - pins 12,13 input only, no pull asleep
// - data write drives gpio outputs; read pins
// - output enable per pin, resets zero
// - pull enable per pin, low 26 set
// - drive strength per pin, resets zero
// - sense selects edge or level detection
// - both-edges selects single or both edges
// - polarity selects falling/low or rising/high
// - interrupt mask per pin, resets zero
// - raw pending readable, unmasked
// - masked pending readable
// - writing one clears pending bit
// - four function select registers, 3-bit codes
// - pins 9,10 reset to alternate one
// - set register forces data bits high
// - clear register forces data bits low
// - capture select routes pins to timers
// - matching pin condition sets raw pending
// - masked equals mask and raw pending
// - masked pending ORed into one interrupt
module general_purpose_io_port #(
  parameter int unsigned PINS = gpio_port_pkg::PIN_COUNT
) (
  // clock, reset, clock enable
  input  wire logic                              ref_clk,
  input  wire logic                              rstn,
  input  wire logic                              clkEn,
  // register port
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [gpio_port_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [gpio_port_pkg::DATA_W-1:0]  regRdata,
  // power state
  input  wire logic                              lowPower,
  // pads
  input  wire logic [PINS-1:0]                   pinIn,
  output logic      [PINS-1:0]                   pinOut,
  output logic      [PINS-1:0]                   pinOe,
  output logic      [PINS-1:0]                   pinPull,
  output logic      [PINS-1:0]                   pinHighDrive,
  // alternate peripherals
  input  wire logic [PINS-1:0]                   altZeroOut,
  input  wire logic [PINS-1:0]                   altZeroOe,
  input  wire logic [PINS-1:0]                   altOneOut,
  input  wire logic [PINS-1:0]                   altOneOe,
  input  wire logic [PINS-1:0]                   altTwoOut,
  input  wire logic [PINS-1:0]                   altTwoOe,
  output logic      [PINS-1:0]                   altIn,
  // timer capture and interrupt
  output logic      [gpio_port_pkg::CAPTURE_COUNT-1:0] timerCapture,
  output logic                                   irq
);
  import gpio_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0] dataR_r, oenR_r, pullR_r, driveR_r;
  logic [31:0] senseR_r, bothR_r, polR_r, maskR_r;
  logic [31:0] fsel_r [FUNC_REG_COUNT];
  logic [31:0] capSel_r, sleepCfg_r;
  logic [31:0] dataR_nxt, oenR_nxt, pullR_nxt, driveR_nxt;
  logic [31:0] senseR_nxt, bothR_nxt, polR_nxt, maskR_nxt;
  logic [31:0] fsel_nxt [FUNC_REG_COUNT];
  logic [31:0] capSel_nxt, sleepCfg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [PINS-1:0] clearPend;

  // pin state
  logic [PINS-1:0] out_r, oe_r, pull_r, drv_r;
  logic [PINS-1:0] out_nxt, oe_nxt, pull_nxt, drv_nxt;
  logic [CAPTURE_COUNT-1:0] cap_r, cap_nxt;
  logic irq_r, irq_nxt;

  // detector results
  logic [PINS-1:0] pinSync, rawPend, maskedPend;
  logic            wrOk, rdOk;

  ////////////////////////////////////////////////////////////////////////////
  // 3-bit function code of one pin
  function automatic logic [2:0] funcOf(input int unsigned pin);
    logic [31:0] sel;
    sel = fsel_r[pin / FUNC_PINS_PER_REG];
    funcOf = sel[(pin % FUNC_PINS_PER_REG) * FUNC_FIELD_STRIDE +: 3];
  endfunction

  // widen a per-pin vector to a 32-bit bus word, upper bits zero
  function automatic logic [31:0] toWord(input logic [PINS-1:0] v);
    toWord = '0;
    toWord[PINS-1:0] = v;
  endfunction

  // word-aligned strobe; a stray byte address must not alias a neighbour
  function automatic logic aligned(input logic [ADDR_W-1:0] addr);
    aligned = (addr[1:0] == 2'h0);
  endfunction

  // one bit of the sleep config for pins 9..11, field starting at lsb
  function automatic logic sleepBit(input int unsigned lsb, input int unsigned pin);
    sleepBit = sleepCfg_r[lsb + pin - SLEEP_CFG_PIN_LO];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  pin_event_detect #(
    .N (PINS)
  ) u_detect (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .pinIn      (pinIn),
    .levelSense (senseR_r[PINS-1:0]),
    .bothEdges  (bothR_r[PINS-1:0]),
    .polarity   (polR_r[PINS-1:0]),
    .clearPend  (clearPend),
    .pinSync    (pinSync),
    .pending    (rawPend)
  );

  assign maskedPend = maskR_r[PINS-1:0] & rawPend;

  ////////////////////////////////////////////////////////////////////////////
  // register writes; misaligned addresses are ignored
  assign wrOk = regWr & aligned(regAddr);
  assign rdOk = regRd & aligned(regAddr);

  always_comb begin
    dataR_nxt    = dataR_r;
    oenR_nxt     = oenR_r;
    pullR_nxt    = pullR_r;
    driveR_nxt   = driveR_r;
    senseR_nxt   = senseR_r;
    bothR_nxt    = bothR_r;
    polR_nxt     = polR_r;
    maskR_nxt    = maskR_r;
    fsel_nxt     = fsel_r;
    capSel_nxt   = capSel_r;
    sleepCfg_nxt = sleepCfg_r;
    clearPend    = '0;
    if (wrOk) begin
      case (regAddr)
        OFS_PIN_DATA:       dataR_nxt  = regWdata;
        OFS_OUTPUT_ENABLE:  oenR_nxt   = regWdata;
        OFS_PULL_ENABLE:    pullR_nxt  = regWdata;
        OFS_DRIVE_STRENGTH: driveR_nxt = regWdata;
        OFS_EDGE_OR_LEVEL:  senseR_nxt = regWdata;
        OFS_BOTH_EDGES:     bothR_nxt  = regWdata;
        OFS_EVENT_POLARITY: polR_nxt   = regWdata;
        OFS_INTERRUPT_MASK: maskR_nxt  = regWdata;
        OFS_PENDING_CLEAR:  clearPend  = regWdata[PINS-1:0];
        OFS_FUNC_SEL_0_7:   fsel_nxt[0] = regWdata;
        OFS_FUNC_SEL_8_15:  fsel_nxt[1] = regWdata;
        OFS_FUNC_SEL_16_23: fsel_nxt[2] = regWdata;
        OFS_FUNC_SEL_24_25: fsel_nxt[3] = regWdata;
        // set and clear act in any mode; the mux decides what reaches a pad
        OFS_DATA_BIT_SET:   dataR_nxt  = dataR_r | regWdata;
        OFS_DATA_BIT_CLEAR: dataR_nxt  = dataR_r & ~regWdata;
        OFS_TIMER_CAPTURE:  capSel_nxt = regWdata;
        OFS_SLEEP_PIN_CFG:  sleepCfg_nxt = regWdata;
        default: begin
        end
      endcase
    end
  end

  // clkEn low freezes the bank; a strobe in such a cycle is lost
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dataR_r    <= RST_PIN_DATA;
      oenR_r     <= RST_ZERO;
      pullR_r    <= RST_PULL_ENABLE;
      driveR_r   <= RST_ZERO;
      senseR_r   <= RST_ZERO;
      bothR_r    <= RST_ZERO;
      polR_r     <= RST_ZERO;
      maskR_r    <= RST_ZERO;
      fsel_r[0]  <= RST_ZERO;
      fsel_r[1]  <= RST_FUNC_SEL_8_15;
      fsel_r[2]  <= RST_ZERO;
      fsel_r[3]  <= RST_ZERO;
      capSel_r   <= RST_ZERO;
      sleepCfg_r <= RST_ZERO;
    end else if (clkEn) begin
      dataR_r    <= dataR_nxt;
      oenR_r     <= oenR_nxt;
      pullR_r    <= pullR_nxt;
      driveR_r   <= driveR_nxt;
      senseR_r   <= senseR_nxt;
      bothR_r    <= bothR_nxt;
      polR_r     <= polR_nxt;
      maskR_r    <= maskR_nxt;
      fsel_r     <= fsel_nxt;
      capSel_r   <= capSel_nxt;
      sleepCfg_r <= sleepCfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads: data appear the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = '0;
    if (rdOk) begin
      case (regAddr)
        // pad levels, so an input pin reads back what is outside
        OFS_PIN_DATA:       rdata_nxt = toWord(pinSync);
        OFS_OUTPUT_ENABLE:  rdata_nxt = oenR_r;
        OFS_PULL_ENABLE:    rdata_nxt = pullR_r;
        OFS_DRIVE_STRENGTH: rdata_nxt = driveR_r;
        OFS_EDGE_OR_LEVEL:  rdata_nxt = senseR_r;
        OFS_BOTH_EDGES:     rdata_nxt = bothR_r;
        OFS_EVENT_POLARITY: rdata_nxt = polR_r;
        OFS_INTERRUPT_MASK: rdata_nxt = maskR_r;
        OFS_RAW_PENDING:    rdata_nxt = toWord(rawPend);
        OFS_MASKED_PENDING: rdata_nxt = toWord(maskedPend);
        OFS_FUNC_SEL_0_7:   rdata_nxt = fsel_r[0];
        OFS_FUNC_SEL_8_15:  rdata_nxt = fsel_r[1];
        OFS_FUNC_SEL_16_23: rdata_nxt = fsel_r[2];
        OFS_FUNC_SEL_24_25: rdata_nxt = fsel_r[3];
        OFS_TIMER_CAPTURE:  rdata_nxt = capSel_r;
        OFS_SLEEP_PIN_CFG:  rdata_nxt = sleepCfg_r;
        // clear, set and bit-clear strobes hold nothing and read zero
        default:            rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (clkEn) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin muxing: registered so the pad sees no glitches
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      out_nxt[i]  = 1'b0;
      oe_nxt[i]   = 1'b0;
      pull_nxt[i] = pullR_r[i];
      drv_nxt[i]  = driveR_r[i];
      if (lowPower) begin
        if (i >= SLEEP_CFG_PIN_LO && i < INPUT_ONLY_LO) begin
          // sleep config overrides the mode so these stay usable asleep
          oe_nxt[i]   = sleepBit(SLEEP_DIR_LSB, i);
          pull_nxt[i] = sleepBit(SLEEP_PULL_LSB, i);
          out_nxt[i]  = dataR_r[i];
        end else begin
          // undriven and unpulled; 12 and 13 stay plain inputs
          pull_nxt[i] = 1'b0;
        end
      end else if (i == INPUT_ONLY_LO || i == INPUT_ONLY_HI) begin
        oe_nxt[i] = 1'b0;
      end else begin
        case (pin_func_t'(funcOf(i)))
          FUNC_GPIO: begin
            out_nxt[i] = dataR_r[i];
            oe_nxt[i]  = oenR_r[i];
          end
          FUNC_ALT_0: begin
            out_nxt[i] = altZeroOut[i];
            oe_nxt[i]  = altZeroOe[i];
          end
          FUNC_ALT_1: begin
            out_nxt[i] = altOneOut[i];
            oe_nxt[i]  = altOneOe[i];
          end
          FUNC_ALT_2: begin
            out_nxt[i] = altTwoOut[i];
            oe_nxt[i]  = altTwoOe[i];
          end
          // unlisted codes leave the pin an input
          default: begin
            out_nxt[i] = 1'b0;
            oe_nxt[i]  = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_r  <= '0;
      oe_r   <= '0;
      // pulls on through reset keep every undriven pad at a known level
      pull_r <= RST_PULL_ENABLE[PINS-1:0];
      drv_r  <= '0;
    end else if (clkEn) begin
      out_r  <= out_nxt;
      oe_r   <= oe_nxt;
      pull_r <= pull_nxt;
      drv_r  <= drv_nxt;
    end
  end

  assign pinOut       = out_r;
  assign pinOe        = oe_r;
  assign pinPull      = pull_r;
  assign pinHighDrive = drv_r;
  assign altIn        = pinSync;

  ////////////////////////////////////////////////////////////////////////////
  // timer capture routing and interrupt line
  always_comb begin
    logic [CAPTURE_SEL_W-1:0] idx;
    idx = '0;
    for (int t = 0; t < CAPTURE_COUNT; t++) begin
      idx = capSel_r[t * CAPTURE_STRIDE +: CAPTURE_SEL_W];
      // out-of-range indices give a quiet low input
      cap_nxt[t] = (32'(idx) < PINS) ? pinSync[idx] : 1'b0;
    end
    // registered: a cycle late, but no glitch reaches the controller
    irq_nxt = |maskedPend;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap_r <= '0;
      irq_r <= 1'b0;
    end else if (clkEn) begin
      cap_r <= cap_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign timerCapture = cap_r;
  assign irq          = irq_r;

endmodule

// ---- core/gpio_port_pkg.sv ----
// constants shared by the general purpose io port and its event detector
package gpio_port_pkg;

  localparam int unsigned PIN_COUNT = 26;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;

  // register byte offsets
  localparam logic [7:0] OFS_PIN_DATA       = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_PULL_ENABLE    = 8'h08;
  localparam logic [7:0] OFS_DRIVE_STRENGTH = 8'h0c;
  localparam logic [7:0] OFS_EDGE_OR_LEVEL  = 8'h10;
  localparam logic [7:0] OFS_BOTH_EDGES     = 8'h14;
  localparam logic [7:0] OFS_EVENT_POLARITY = 8'h18;
  localparam logic [7:0] OFS_INTERRUPT_MASK = 8'h1c;
  localparam logic [7:0] OFS_RAW_PENDING    = 8'h20;
  localparam logic [7:0] OFS_MASKED_PENDING = 8'h24;
  localparam logic [7:0] OFS_PENDING_CLEAR  = 8'h28;
  localparam logic [7:0] OFS_FUNC_SEL_0_7   = 8'h2c;
  localparam logic [7:0] OFS_FUNC_SEL_8_15  = 8'h30;
  localparam logic [7:0] OFS_FUNC_SEL_16_23 = 8'h34;
  localparam logic [7:0] OFS_FUNC_SEL_24_25 = 8'h38;
  localparam logic [7:0] OFS_DATA_BIT_SET   = 8'h3c;
  localparam logic [7:0] OFS_DATA_BIT_CLEAR = 8'h40;
  localparam logic [7:0] OFS_TIMER_CAPTURE  = 8'h44;
  localparam logic [7:0] OFS_SLEEP_PIN_CFG  = 8'h48;

  // reset values
  localparam logic [31:0] RST_PIN_DATA      = 32'h00000000;
  localparam logic [31:0] RST_ZERO          = 32'h00000000;
  localparam logic [31:0] RST_PULL_ENABLE   = 32'h03ffffff;
  localparam logic [31:0] RST_FUNC_SEL_8_15 = 32'h00000110;

  // function field layout: 3 bits every 4, 8 pins per register
  localparam int unsigned FUNC_PINS_PER_REG = 8;
  localparam int unsigned FUNC_FIELD_STRIDE = 4;
  localparam int unsigned FUNC_REG_COUNT    = 4;

  typedef enum logic [2:0] {
    FUNC_GPIO  = 3'h0,
    FUNC_ALT_1 = 3'h1,
    FUNC_ALT_0 = 3'h4,
    FUNC_ALT_2 = 3'h5
  } pin_func_t;

  // special pins
  localparam int unsigned SLEEP_CFG_PIN_LO = 9;
  localparam int unsigned INPUT_ONLY_LO    = 12;
  localparam int unsigned INPUT_ONLY_HI    = 13;

  // sleep pin config layout: direction of pins 9..11, pull of pins 9..11
  localparam int unsigned SLEEP_DIR_LSB  = 0;
  localparam int unsigned SLEEP_PULL_LSB = 4;

  // timer capture select layout: 5-bit pin index per timer input
  localparam int unsigned CAPTURE_COUNT   = 2;
  localparam int unsigned CAPTURE_SEL_W   = 5;
  localparam int unsigned CAPTURE_STRIDE  = 8;

endpackage

// ---- core/pin_event_detect.sv ----
// input synchroniser and edge/level event detection with sticky pending bits
`timescale 1ns/100ps
module pin_event_detect #(
  parameter int unsigned N = 26
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  // pins and configuration
  input  wire logic [N-1:0] pinIn,
  input  wire logic [N-1:0] levelSense,
  input  wire logic [N-1:0] bothEdges,
  input  wire logic [N-1:0] polarity,
  input  wire logic [N-1:0] clearPend,
  // results
  output logic      [N-1:0] pinSync,
  output logic      [N-1:0] pending
);
  import gpio_port_pkg::*;

  logic [N-1:0] meta_r, sync_r, prev_r, pend_r;
  logic [N-1:0] meta_nxt, sync_nxt, prev_nxt, pend_nxt;
  logic [N-1:0] rise, fall, hit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    meta_nxt = pinIn;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    rise     = sync_r & ~prev_r;
    fall     = ~sync_r & prev_r;
    for (int i = 0; i < N; i++) begin
      if (levelSense[i]) begin
        hit[i] = polarity[i] ? sync_r[i] : ~sync_r[i];
      end else if (bothEdges[i]) begin
        hit[i] = rise[i] | fall[i];
      end else begin
        hit[i] = polarity[i] ? rise[i] : fall[i];
      end
    end
    // set wins over clear; a lasting level sets again at once
    pend_nxt = (pend_r & ~clearPend) | hit;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      pend_r <= '0;
    end else if (clkEn) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign pinSync = sync_r;
  assign pending = pend_r;

endmodule

// ---- bench/gpio_port_props.sv ----
// checker of the io port register and pin behaviour
`timescale 1ns/100ps
module gpio_port_props #(
  parameter int unsigned PINS = gpio_port_pkg::PIN_COUNT
) (
  // clock and reset
  input wire logic                             ref_clk,
  input wire logic                             rstn,
  input wire logic                             clkEn,
  // register port
  input wire logic [gpio_port_pkg::ADDR_W-1:0] regAddr,
  input wire logic [gpio_port_pkg::DATA_W-1:0] regWdata,
  input wire logic                             regWr,
  input wire logic                             regRd,
  input wire logic [gpio_port_pkg::DATA_W-1:0] regRdata,
  // pins and interrupt
  input wire logic                             lowPower,
  input wire logic [PINS-1:0]                  pinOe,
  input wire logic [PINS-1:0]                  pinPull,
  input wire logic [PINS-1:0]                  pinHighDrive,
  input wire logic                             irq
);
  import gpio_port_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // pins 9..11 keep their own sleep setting
  logic [PINS-1:0] outerMask;
  assign outerMask = ~(PINS'(7) << SLEEP_CFG_PIN_LO);
  //////////////////////////////////////////////////////////////////////////////
  sequence rdAt(logic [7:0] a);
    clkEn && regRd && regAddr == a;
  endsequence
  sequence wrDrive;
    clkEn && regWr && regAddr == OFS_DRIVE_STRENGTH ##1 clkEn;
  endsequence
  sequence wrMaskOff;
    clkEn && regWr && regAddr == OFS_INTERRUPT_MASK && regWdata == '0 ##1 clkEn [*2];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_reset_undriven: assert property (disable iff (1'b0)
    !rstn |-> pinOe == '0 && pinHighDrive == '0 && pinPull == '1)
    else $error("pins driven during reset");
  a_read_idle_zero: assert property ($past(clkEn) && !$past(regRd) |-> regRdata == '0)
    else $error("read data outside read cycle");
  a_clear_reads_zero: assert property (rdAt(OFS_PENDING_CLEAR) |=> regRdata == '0)
    else $error("write-only register read nonzero");
  a_raw_upper_zero: assert property (rdAt(OFS_RAW_PENDING) |=> regRdata[31:PINS] == '0)
    else $error("raw status upper bits set");
  a_irq_masked_or: assert property (rdAt(OFS_MASKED_PENDING) |=>
    irq == (regRdata != '0) && regRdata[31:PINS] == '0)
    else $error("irq differs from masked status");
  a_sleep_no_drive: assert property ($past(clkEn) && $past(lowPower) && lowPower
    |-> (pinOe & outerMask) == '0)
    else $error("pin driven in low power");
  a_sleep_no_pull: assert property ($past(clkEn) && $past(lowPower) && lowPower
    |-> (pinPull & outerMask) == '0)
    else $error("pull applied in low power");
  a_input_only_pins: assert property (pinOe[INPUT_ONLY_HI:INPUT_ONLY_LO] == 2'h0)
    else $error("input-only pin driven");
  a_drive_follows: assert property (wrDrive |=> pinHighDrive == $past(regWdata[PINS-1:0], 2))
    else $error("drive strength not applied");
  a_mask_off_irq: assert property (wrMaskOff |=> !irq)
    else $error("irq with all interrupts masked");
endmodule

bind general_purpose_io_port gpio_port_props #(.PINS(PINS)) props_u (
  .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .lowPower(lowPower), .pinOe(pinOe),
  .pinPull(pinPull), .pinHighDrive(pinHighDrive), .irq(irq));

// ---- bench/pad_model.sv ----
// pad and external driver model for the io port pins
`timescale 1ns/100ps
module pad_model #(
  parameter int unsigned PINS = 26
) (
  // clock
  input  wire logic            ref_clk,
  // from the port
  input  wire logic [PINS-1:0] pinOut,
  input  wire logic [PINS-1:0] pinOe,
  input  wire logic [PINS-1:0] pinPull,
  // external drivers
  input  wire logic [PINS-1:0] extEn,
  input  wire logic [PINS-1:0] extVal,
  // pad level seen by the port
  output logic      [PINS-1:0] pinIn
);
  // pins 9..11 pull up, the rest pull down
  localparam logic [PINS-1:0] PULL_UP = PINS'(32'h00000e00);
  logic flip = 1'b0;
  // a floating pad wanders so a missing drive cannot pass as a constant
  always @(posedge ref_clk) flip <= !flip;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extVal[i];
      else if (pinPull[i]) pinIn[i] = PULL_UP[i];
      else pinIn[i] = flip ^ i[0];
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// register-level testbench of the general purpose io port
`timescale 1ns/100ps
module tb_top;
  import gpio_port_pkg::*;
  localparam logic [31:0] B20 = 32'h00100000;
  localparam logic [2:0] CODES [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
  localparam logic [31:0] EXPS [4] = '{32'h0, 32'h3, 32'h2, 32'h0};
  localparam logic [7:0] RWA [5] = '{8'h0c, 8'h14, 8'h18, 8'h34, 8'h38};
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b1;
  logic        clkEn = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata, expv;
  logic        regWr = 1'b0, regRd = 1'b0, lowPower = 1'b0, irq;
  logic [25:0] altZeroOut = '0, altZeroOe = '0, altOneOut = '0, altOneOe = '0;
  logic [25:0] altTwoOut = '0, altTwoOe = '0, extEn = '0, extVal = '0;
  logic [25:0] pinIn, pinOut, pinOe, pinPull, pinHighDrive, altIn;
  logic [1:0]  timerCapture;
  int          errorCnt = 0, checkCount = 0, cyc = 0;

  always #2 ref_clk = !ref_clk;

  general_purpose_io_port dut_u (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .lowPower(lowPower), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPull(pinPull), .pinHighDrive(pinHighDrive), .altZeroOut(altZeroOut),
    .altZeroOe(altZeroOe), .altOneOut(altOneOut), .altOneOe(altOneOe),
    .altTwoOut(altTwoOut), .altTwoOe(altTwoOe), .altIn(altIn),
    .timerCapture(timerCapture), .irq(irq));
  pad_model pad_u (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe), .pinPull(pinPull),
    .extEn(extEn), .extVal(extVal), .pinIn(pinIn));
  //////////////////////////////////////////////////////////////////////////////
  task testDone;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task chkRd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask
  // hang guard, well above the length of the sequence
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errorCnt++;
      testDone();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn <= 1'b0;
    tick(5);
    chk(32'(pinOe), 32'h0);
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    tick(4);
    for (int a = 0; a <= 8'h4c; a += 4) begin
      expv = 32'h0;
      if (a == 0) expv = 32'h00000e00;
      if (a == 8'h08) expv = 32'h03ffffff;
      if (a == 8'h30) expv = 32'h00000110;
      chkRd(8'(a), expv);
    end
    chkRd(8'h09, 32'h0);
    foreach (RWA[i]) begin
      wr(RWA[i], 32'hc2a5a5a5);
      chkRd(RWA[i], 32'hc2a5a5a5);
      if (i == 0) chk(32'(pinHighDrive), 32'h02a5a5a5);
      wr(RWA[i], 32'h0);
    end
    wr(OFS_RAW_PENDING, 32'hffffffff);
    chkRd(OFS_RAW_PENDING, 32'h0);
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(OFS_DRIVE_STRENGTH, 32'h1);
    clkEn <= 1'b1;
    wr(8'h0d, 32'hff);
    chkRd(OFS_DRIVE_STRENGTH, 32'h0);
    // data, set and clear on pins 0 and 5
    wr(OFS_OUTPUT_ENABLE, 32'h21);
    wr(OFS_PIN_DATA, 32'h1);
    wr(OFS_DATA_BIT_SET, 32'h20);
    tick(3);
    chk(32'(pinOut & 26'h21), 32'h21);
    wr(OFS_DATA_BIT_CLEAR, 32'h1);
    tick(3);
    chk(32'(pinOut & 26'h21), 32'h20);
    chkRd(OFS_PIN_DATA, 32'h00000e20);
    chk(32'(altIn), 32'h00000e20);
    wr(OFS_TIMER_CAPTURE, 32'h00000514);
    tick(4);
    chk(32'(timerCapture), 32'h2);
    // function codes on pin 0, reset mode of pin 9
    wr(OFS_OUTPUT_ENABLE, 32'h20);
    altOneOe <= '1;
    altOneOut <= '1;
    altZeroOe <= '1;
    tick(3);
    chk(32'({pinOe[9], pinOut[9]}), 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_FUNC_SEL_0_7, {29'h0, CODES[i]});
      tick(3);
      chk(32'({pinOe[0], pinOe[0] & pinOut[0]}), EXPS[i]);
    end
    wr(OFS_FUNC_SEL_0_7, 32'h0);
    altOneOe <= '0;
    altZeroOe <= '0;
    // interrupts on an externally driven pin 20
    extEn[20] <= 1'b1;
    chkRd(OFS_RAW_PENDING, 32'h1);
    wr(OFS_EVENT_POLARITY, B20);
    wr(OFS_PENDING_CLEAR, B20 | 32'h1);
    wr(OFS_INTERRUPT_MASK, B20);
    extVal[20] <= 1'b1;
    tick(6);
    chkRd(OFS_RAW_PENDING, B20);
    chkRd(OFS_MASKED_PENDING, B20);
    chk(32'(irq), 32'h1);
    @(posedge ref_clk);
    extVal[20] <= 1'b0;
    wr(OFS_PENDING_CLEAR, B20 | 32'h1);
    tick(6);
    chkRd(OFS_RAW_PENDING, 32'h0);
    chk(32'(irq), 32'h0);
    wr(OFS_BOTH_EDGES, B20);
    extVal[20] <= 1'b1;
    tick(6);
    wr(OFS_PENDING_CLEAR, B20);
    extVal[20] <= 1'b0;
    tick(6);
    chkRd(OFS_RAW_PENDING, B20);
    wr(OFS_BOTH_EDGES, 32'h0);
    wr(OFS_EDGE_OR_LEVEL, B20);
    extVal[20] <= 1'b1;
    tick(6);
    wr(OFS_PENDING_CLEAR, B20);
    tick(2);
    chkRd(OFS_RAW_PENDING, B20);
    wr(OFS_INTERRUPT_MASK, 32'h0);
    tick(3);
    chkRd(OFS_MASKED_PENDING, 32'h0);
    chk(32'(irq), 32'h0);
    @(posedge ref_clk);
    extVal[20] <= 1'b0;
    tick(6);
    wr(OFS_PENDING_CLEAR, B20);
    chkRd(OFS_RAW_PENDING, 32'h0);
    // low power pin states
    @(posedge ref_clk);
    lowPower <= 1'b1;
    tick(3);
    chk(32'(pinOe), 32'h0);
    chk(32'(pinPull), 32'h0);
    wr(OFS_SLEEP_PIN_CFG, 32'h21);
    tick(3);
    chk(32'({pinOe[11:9], pinPull[11:9]}), 32'h0a);
    @(posedge ref_clk);
    lowPower <= 1'b0;
    tick(3);
    testDone();
  end
endmodule
